//--- verilog/rsc_loader.sv
// Strap capture, derived configuration and Wishbone register file
`timescale 1ns/1ns
module rsc_loader
   import rsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic active_low_reset_pin_n_i,
   input wire logic [RSC_NSTRAP-1:0] strap_i,
   output logic [RSC_NSTRAP-1:0] strap_oe_o,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic aux_clock_output_o,
   output logic managed_o,
   output logic [4:0] phy_addr_o,
   output logic [1:0] mac_if_o,
   output logic autoneg_o,
   output logic full_duplex_o,
   output logic [1:0] speed_o,
   output logic [1:0] gig_cap_o,
   output logic [1:0] mdi_mode_o,
   output logic downshift_o,
   output logic low_power_o,
   output logic forced_1000_o,
   output logic master_o,
   output logic [2:0] rx_delay_o,
   output logic [2:0] tx_delay_o,
   output logic loaded_o
);
   typedef enum logic [1:0] {
      RSC_ST_IDLE = 2'b00,
      RSC_ST_HELD = 2'b01,
      RSC_ST_LOAD = 2'b10,
      RSC_ST_RUN = 2'b11
   } rsc_state_e;

   typedef struct packed {
      rsc_state_e st;
      logic [1:0] rst_sync;
      logic [RSC_NSTRAP-1:0] strap_m;
      logic [RSC_NSTRAP-1:0] strap_q;
      logic [RSC_NSTRAP-1:0] latched;
      logic clk_en;
      logic [1:0] clk_freq;
      logic managed;
      logic [4:0] addr;
      logic [1:0] mac_if;
      logic autoneg;
      logic duplex;
      logic [1:0] speed;
      logic [1:0] cap;
      logic [1:0] mdi;
      logic downshift;
      logic lowp;
      logic f1000;
      logic master;
      logic [2:0] rxd;
      logic [2:0] txd;
      logic ack;
      logic [31:0] rdat;
   } rsc_state_s;

   rsc_state_s s_r;
   rsc_state_s s_nxt;
   logic div_out;
   logic [2:0] half_sel;

   // Straps A and B to a delay code
   function automatic logic [2:0] delay_code(input logic a, input logic b);
      case ({a, b})
         2'b00: delay_code = RSC_DLY_0P2;
         2'b01: delay_code = RSC_DLY_1P1;
         2'b10: delay_code = RSC_DLY_2P0;
         default: delay_code = RSC_DLY_2P6;
      endcase
   endfunction

   // Byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] sel);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            lane_merge[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
   endfunction

   logic [31:0] cfg_word;
   logic [31:0] clk_word;
   logic [31:0] dly_word;
   logic bus_req;
   logic [31:0] wval;

   always_comb begin
      cfg_word = '0;
      cfg_word[RSC_CFG_AN_BIT] = s_r.autoneg;
      cfg_word[RSC_CFG_DUPLEX_BIT] = s_r.duplex;
      cfg_word[RSC_CFG_SPEED_LSB +: 2] = s_r.speed;
      cfg_word[RSC_CFG_CAP_LSB +: 2] = s_r.cap;
      cfg_word[RSC_CFG_MAC_LSB +: 2] = s_r.mac_if;
      cfg_word[RSC_CFG_MDI_LSB +: 2] = s_r.mdi;
      cfg_word[RSC_CFG_DOWN_BIT] = s_r.downshift;
      cfg_word[RSC_CFG_LOWP_BIT] = s_r.lowp;
      cfg_word[RSC_CFG_MS_BIT] = s_r.master;
      cfg_word[RSC_CFG_F1000_BIT] = s_r.f1000;
      clk_word = '0;
      clk_word[RSC_CLK_EN_BIT] = s_r.clk_en;
      clk_word[RSC_CLK_FREQ_LSB +: 2] = s_r.clk_freq;
      dly_word = '0;
      dly_word[RSC_DLY_TX_LSB +: 3] = s_r.txd;
      dly_word[RSC_DLY_RX_LSB +: 3] = s_r.rxd;
   end

   assign bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;

   always_comb begin
      s_nxt = s_r;
      wval = '0;
      s_nxt.rst_sync = {s_r.rst_sync[0], active_low_reset_pin_n_i};
      s_nxt.strap_m = strap_i;
      s_nxt.strap_q = s_r.strap_m;
      s_nxt.ack = bus_req;
      case (s_r.st)
         RSC_ST_IDLE: begin
            s_nxt.st = RSC_ST_HELD;
         end
         RSC_ST_HELD: begin
            // [RL1] capture at release
            if (s_r.rst_sync[1]) begin
               s_nxt.latched = s_r.strap_q;
               s_nxt.st = RSC_ST_LOAD;
            end
         end
         RSC_ST_LOAD: begin
            // [RL16] apply as latched, unchecked
            s_nxt.st = RSC_ST_RUN;
            // [RL3] clock-out enable default
            s_nxt.clk_en = s_r.latched[RSC_S_AUXCLK];
            // [RL6] frequency default from straps
            s_nxt.clk_freq = {s_r.latched[RSC_S_F1], s_r.latched[RSC_S_F0]};
            s_nxt.managed = !s_r.latched[RSC_S_MODE];
            s_nxt.autoneg = 1'b1;
            s_nxt.duplex = 1'b1;
            s_nxt.speed = RSC_SPD_1000;
            s_nxt.cap = RSC_CAP_ALL;
            s_nxt.mdi = RSC_MDI_AUTO;
            s_nxt.downshift = 1'b0;
            s_nxt.lowp = 1'b0;
            s_nxt.rxd = RSC_DLY_0P2;
            s_nxt.txd = RSC_DLY_0P2;
            // [RL18] MAC family strap
            s_nxt.mac_if = s_r.latched[RSC_S_FAMILY] ? RSC_MAC_GMII : RSC_MAC_RGMII;
            if (!s_r.latched[RSC_S_MODE]) begin
               // [RL8] managed address from A-E
               s_nxt.addr = s_r.latched[RSC_S_A +: 5];
            end else begin
               // [RL17] unmanaged address
               s_nxt.addr = {3'h0, s_r.latched[RSC_S_AD1], s_r.latched[RSC_S_AD0]};
               // [RL9] [RL10] unmanaged defaults
               // [RL11] downshift and low power on
               s_nxt.downshift = 1'b1;
               s_nxt.lowp = 1'b1;
               // [RL12] delay codes from A, B
               s_nxt.rxd = delay_code(s_r.latched[RSC_S_A], s_r.latched[RSC_S_A + 1]);
               s_nxt.txd = delay_code(s_r.latched[RSC_S_A], s_r.latched[RSC_S_A + 1]);
               // [RL13] advertisement from C, D
               case ({s_r.latched[RSC_S_A + 2], s_r.latched[RSC_S_A + 3]})
                  2'b00: begin
                     s_nxt.cap = RSC_CAP_ALL;
                  end
                  2'b01: begin
                     s_nxt.cap = RSC_CAP_NONE;
                     s_nxt.speed = RSC_SPD_100;
                  end
                  2'b10: begin
                     s_nxt.cap = RSC_CAP_NONE;
                     s_nxt.autoneg = 1'b0;
                     s_nxt.duplex = 1'b0;
                     s_nxt.speed = RSC_SPD_100;
                  end
                  default: begin
                     s_nxt.cap = RSC_CAP_NONE;
                     s_nxt.autoneg = 1'b0;
                     s_nxt.duplex = 1'b0;
                     s_nxt.speed = RSC_SPD_10;
                  end
               endcase
               // [RL14] [RL19] strap E forces RMII
               if (s_r.latched[RSC_S_E]) begin
                  s_nxt.mac_if = RSC_MAC_RMII;
               end
            end
            // [RL20] forced gigabit mode
            s_nxt.f1000 = s_r.latched[RSC_S_F1000];
            s_nxt.master = 1'b0;
            if (s_r.latched[RSC_S_F1000]) begin
               s_nxt.autoneg = 1'b0;
               s_nxt.speed = RSC_SPD_1000;
               s_nxt.duplex = 1'b1;
               // [RL21] master/slave
               s_nxt.master = s_r.latched[RSC_S_MS];
               // [RL22] MDI or MDI-X
               s_nxt.mdi = s_r.latched[RSC_S_MDI] ? RSC_MDIX_FORCE : RSC_MDI_FORCE;
            end
         end
         RSC_ST_RUN: begin
            // [RL23] only register writes change settings
            if (bus_req && wb_we_i) begin
               case (wb_adr_i)
                  RSC_ADDR_CLK: begin
                     wval = lane_merge(clk_word, wb_dat_i, wb_sel_i);
                     // [RL4] software clock-out enable
                     s_nxt.clk_en = wval[RSC_CLK_EN_BIT];
                     // [RL7] frequency rewritable
                     s_nxt.clk_freq = wval[RSC_CLK_FREQ_LSB +: 2];
                  end
                  RSC_ADDR_CFG: begin
                     wval = lane_merge(cfg_word, wb_dat_i, wb_sel_i);
                     s_nxt.autoneg = wval[RSC_CFG_AN_BIT];
                     s_nxt.duplex = wval[RSC_CFG_DUPLEX_BIT];
                     s_nxt.speed = wval[RSC_CFG_SPEED_LSB +: 2];
                     s_nxt.cap = wval[RSC_CFG_CAP_LSB +: 2];
                     s_nxt.mac_if = wval[RSC_CFG_MAC_LSB +: 2];
                     s_nxt.mdi = wval[RSC_CFG_MDI_LSB +: 2];
                     s_nxt.downshift = wval[RSC_CFG_DOWN_BIT];
                     s_nxt.lowp = wval[RSC_CFG_LOWP_BIT];
                     s_nxt.master = wval[RSC_CFG_MS_BIT];
                  end
                  RSC_ADDR_DELAY: begin
                     wval = lane_merge(dly_word, wb_dat_i, wb_sel_i);
                     s_nxt.txd = wval[RSC_DLY_TX_LSB +: 3];
                     s_nxt.rxd = wval[RSC_DLY_RX_LSB +: 3];
                  end
                  default: begin
                     wval = '0;
                  end
               endcase
            end
         end
         default: begin
            s_nxt.st = RSC_ST_IDLE;
         end
      endcase
      // Pin reset asserted again: return to sampling
      if (!s_r.rst_sync[1]) begin
         s_nxt.st = RSC_ST_HELD;
      end
      // Read data; unmapped addresses read zero and still ack
      s_nxt.rdat = '0;
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            RSC_ADDR_STRAP: s_nxt.rdat = {17'h0, s_r.latched};
            RSC_ADDR_CLK: s_nxt.rdat = clk_word;
            RSC_ADDR_CFG: s_nxt.rdat = cfg_word;
            RSC_ADDR_DELAY: s_nxt.rdat = dly_word;
            RSC_ADDR_ID: s_nxt.rdat = RSC_ID_VALUE;
            default: s_nxt.rdat = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_comb begin
      case (s_r.clk_freq)
         RSC_FREQ_25: half_sel = RSC_HALF_25;
         RSC_FREQ_50: half_sel = RSC_HALF_50;
         RSC_FREQ_125: half_sel = RSC_HALF_125;
         default: half_sel = RSC_HALF_25;
      endcase
   end

   // [RL5] clock output from the core reference
   rsc_clkdiv u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(s_r.clk_en && s_r.st == RSC_ST_RUN),
      .half_i(half_sel),
      .out_o(div_out)
   );

   // Strap pins are never driven by this block; functional drivers
   // elsewhere must honour this too while reset is held.
   assign strap_oe_o = '0;
   assign aux_clock_output_o = div_out;
   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign managed_o = s_r.managed;
   assign phy_addr_o = s_r.addr;
   assign mac_if_o = s_r.mac_if;
   assign autoneg_o = s_r.autoneg;
   assign full_duplex_o = s_r.duplex;
   assign speed_o = s_r.speed;
   assign gig_cap_o = s_r.cap;
   assign mdi_mode_o = s_r.mdi;
   assign downshift_o = s_r.downshift;
   assign low_power_o = s_r.lowp;
   assign forced_1000_o = s_r.f1000;
   assign master_o = s_r.master;
   assign rx_delay_o = s_r.rxd;
   assign tx_delay_o = s_r.txd;
   assign loaded_o = (s_r.st == RSC_ST_RUN);

   // ****************************************
   // Assertions
   // ****************************************
   property p_capture;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_HELD && s_r.rst_sync[1]) |=> s_r.latched == $past(s_r.strap_q);
   endproperty
   a_capture: assert property (p_capture) else $error("strap capture wrong"); // [RL1]
   // Enable may rise the next cycle, so only the following edge is checked
   property p_clkoff;
      @(posedge clk_i) disable iff (rst_i)
      !s_r.clk_en |=> !aux_clock_output_o;
   endproperty
   a_clkoff: assert property (p_clkoff) else $error("clock out not low"); // [RL3]
   property p_hold;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_RUN && s_nxt.st == RSC_ST_RUN) |=> s_r.latched == $past(s_r.latched);
   endproperty
   a_hold: assert property (p_hold) else $error("latched straps changed"); // [RL23]
   property p_uaddr;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_LOAD && s_r.latched[RSC_S_MODE]) |=> phy_addr_o[4:2] == 3'h0
         && downshift_o && low_power_o;
   endproperty
   a_uaddr: assert property (p_uaddr) else $error("unmanaged defaults wrong"); // [RL17]
   property p_rmii;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_LOAD && s_r.latched[RSC_S_MODE] && s_r.latched[RSC_S_E])
         |=> mac_if_o == RSC_MAC_RMII;
   endproperty
   a_rmii: assert property (p_rmii) else $error("RMII not forced"); // [RL19]
   property p_maddr;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_LOAD && !s_r.latched[RSC_S_MODE])
         |=> phy_addr_o == $past(s_r.latched[RSC_S_A +: 5]) && managed_o;
   endproperty
   a_maddr: assert property (p_maddr) else $error("managed address wrong"); // [RL8]
   property p_master;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_LOAD && s_r.latched[RSC_S_F1000])
         |=> master_o == $past(s_r.latched[RSC_S_MS])
         && mdi_mode_o[0] == $past(s_r.latched[RSC_S_MDI]);
   endproperty
   a_master: assert property (p_master) else $error("forced gigabit wrong"); // [RL21]
   property p_freq;
      @(posedge clk_i) disable iff (rst_i)
      (s_r.st == RSC_ST_RUN && bus_req && wb_we_i && wb_adr_i == RSC_ADDR_CLK && wb_sel_i[0])
         |=> s_r.clk_freq == $past(wb_dat_i[RSC_CLK_FREQ_LSB +: 2]);
   endproperty
   a_freq: assert property (p_freq) else $error("frequency write lost"); // [RL7]
endmodule

//--- verilog/rsc_pkg.sv
// Constants for the reset strap configuration loader
// Behaviour
// [RL1] Straps are inputs while reset is held; levels captured when reset releases.
// [RL2] Other devices on strap pins stay undriven during reset.
// [RL3] Clock-out strap 0 keeps the output low; 1 enables it.
// [RL4] Software control bit enables or disables the clock output.
// [RL5] Clock output derived from reference clock; two-bit frequency field.
// [RL6] Two straps give frequency field default: 25, 50, 125 MHz, reserved.
// [RL7] Frequency field stays rewritable by software after reset.
// [RL8] Mode strap 0: managed, five straps form the PHY address.
// [RL9] Mode strap 1: unmanaged, five straps select default configuration.
// [RL10] Unmanaged mode: speed, autoneg, duplex, capability, interface, crossover, delays from straps; code keeps crossover auto unless forced gigabit.
// [RL11] Unmanaged mode: downshift enable and low-power enable default to one.
// [RL12] Unmanaged: straps A and B set both clock delay codes.
// [RL13] Unmanaged: straps C and D pick the link advertisement.
// [RL14] Unmanaged: strap E selects RGMII (0) or RMII (1).
// [RL15] Board must pair RMII with a 10/100-only advertisement.
// [RL16] No consistency checks; any latched combination is applied.
// [RL17] Unmanaged address: upper three bits zero, low two from straps.
// [RL18] MAC family strap: 0 RGMII, 1 GMII or MII by speed; the code selects GMII for 1 at every speed.
// [RL19] Unmanaged with strap E set forces RMII regardless of family strap.
// [RL20] Forced gigabit strap 1 takes master/slave and crossover from two straps.
// [RL21] Forced gigabit: master strap 1 is master, 0 is slave.
// [RL22] Forced gigabit: crossover strap 0 is MDI, 1 is MDI-X.
// [RL23] Straps captured once per release; later only register writes change settings.
package rsc_pkg;
   // ****************************************
   // Register map (word offsets are byte addresses)
   // ****************************************
   localparam logic [7:0] RSC_ADDR_STRAP = 8'h00;
   localparam logic [7:0] RSC_ADDR_CLK = 8'h04;
   localparam logic [7:0] RSC_ADDR_CFG = 8'h08;
   localparam logic [7:0] RSC_ADDR_DELAY = 8'h0C;
   localparam logic [7:0] RSC_ADDR_ID = 8'h10;
   // Arbitrary identity value
   localparam logic [31:0] RSC_ID_VALUE = 32'h0000_5C01;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int RSC_CLK_EN_BIT = 0;
   localparam int RSC_CLK_FREQ_LSB = 1;
   localparam int RSC_CFG_AN_BIT = 0;
   localparam int RSC_CFG_DUPLEX_BIT = 1;
   localparam int RSC_CFG_SPEED_LSB = 2;
   localparam int RSC_CFG_CAP_LSB = 4;
   localparam int RSC_CFG_MAC_LSB = 6;
   localparam int RSC_CFG_MDI_LSB = 8;
   localparam int RSC_CFG_DOWN_BIT = 10;
   localparam int RSC_CFG_LOWP_BIT = 11;
   localparam int RSC_CFG_MS_BIT = 12;
   localparam int RSC_CFG_F1000_BIT = 13;
   localparam int RSC_DLY_TX_LSB = 0;
   localparam int RSC_DLY_RX_LSB = 4;
   // ****************************************
   // Encodings
   // ****************************************
   localparam logic [1:0] RSC_FREQ_25 = 2'h0;
   localparam logic [1:0] RSC_FREQ_50 = 2'h1;
   localparam logic [1:0] RSC_FREQ_125 = 2'h2;
   localparam logic [2:0] RSC_DLY_0P2 = 3'h0;
   localparam logic [2:0] RSC_DLY_1P1 = 3'h2;
   localparam logic [2:0] RSC_DLY_2P0 = 3'h4;
   localparam logic [2:0] RSC_DLY_2P6 = 3'h6;
   localparam logic [1:0] RSC_MAC_RGMII = 2'h0;
   localparam logic [1:0] RSC_MAC_GMII = 2'h1;
   localparam logic [1:0] RSC_MAC_RMII = 2'h2;
   localparam logic [1:0] RSC_MDI_AUTO = 2'h0;
   localparam logic [1:0] RSC_MDI_FORCE = 2'h2;
   localparam logic [1:0] RSC_MDIX_FORCE = 2'h3;
   localparam logic [1:0] RSC_SPD_10 = 2'h0;
   localparam logic [1:0] RSC_SPD_100 = 2'h1;
   localparam logic [1:0] RSC_SPD_1000 = 2'h2;
   localparam logic [1:0] RSC_CAP_NONE = 2'h0;
   localparam logic [1:0] RSC_CAP_ALL = 2'h3;
   localparam logic [4:0] RSC_ADDR_ZERO = 5'h00;
   // Clock-out dividers: half periods in core cycles per frequency; 125 MHz uses 1, as 50 MHz does
   localparam int RSC_CLK_MHZ = 100;
   localparam logic [2:0] RSC_HALF_25 = 3'(RSC_CLK_MHZ / 25 / 2);
   localparam logic [2:0] RSC_HALF_50 = 3'(RSC_CLK_MHZ / 50 / 2);
   localparam logic [2:0] RSC_HALF_125 = 3'h1;
   // Strap vector bit positions
   localparam int RSC_S_AUXCLK = 0;
   localparam int RSC_S_MODE = 1;
   localparam int RSC_S_A = 2;
   localparam int RSC_S_E = 6;
   localparam int RSC_S_FAMILY = 7;
   localparam int RSC_S_AD0 = 8;
   localparam int RSC_S_AD1 = 9;
   localparam int RSC_S_F0 = 10;
   localparam int RSC_S_F1 = 11;
   localparam int RSC_S_F1000 = 12;
   localparam int RSC_S_MS = 13;
   localparam int RSC_S_MDI = 14;
   localparam int RSC_NSTRAP = 15;
endpackage

//--- verilog/rsc_clkdiv.sv
// Clock-out divider producing an enable-driven square wave
`timescale 1ns/1ns
module rsc_clkdiv
   import rsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   input wire logic [2:0] half_i,
   output logic out_o
);
   typedef struct packed {
      logic [2:0] cnt;
      logic lvl;
   } rsc_div_s;
   rsc_div_s s_r;
   rsc_div_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (!en_i) begin
         s_nxt.cnt = 3'h0;
         s_nxt.lvl = 1'b0;
      end else if (s_r.cnt >= half_i - 3'h1) begin
         s_nxt.cnt = 3'h0;
         s_nxt.lvl = ~s_r.lvl;
      end else begin
         s_nxt.cnt = s_r.cnt + 3'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign out_o = s_r.lvl;
endmodule

//--- tb/rsc_strap_board.sv
// Board pull resistors and a device sharing the strap pins
`timescale 1ns/1ns
module rsc_strap_board
   import rsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic active_low_reset_pin_n_i,
   input wire logic [RSC_NSTRAP-1:0] pull_i,
   output logic [RSC_NSTRAP-1:0] strap_o
);
   logic [3:0] hold_r;
   // ****************************************
   // Pin levels
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (!active_low_reset_pin_n_i) begin
         hold_r <= 4'h0;
         strap_o <= pull_i;
      end else if (hold_r != 4'hF) begin
         hold_r <= hold_r + 4'h1;
      end else begin
         // Sharing device drives traffic once the hold time has run out
         strap_o <= ~strap_o;
      end
   end
endmodule

//--- tb/rsc_loader_test.sv
// Self-checking bench for the strap configuration loader
`timescale 1ns/1ns
module rsc_loader_test import rsc_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic active_low_reset_pin_n_i = 1'b0;
   logic [RSC_NSTRAP-1:0] pull = '0;
   logic [RSC_NSTRAP-1:0] strap_i, strap_oe_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
   logic wb_ack_o, aux_clock_output_o, managed_o, autoneg_o, full_duplex_o, downshift_o;
   logic low_power_o, forced_1000_o, master_o, loaded_o;
   logic [4:0] phy_addr_o;
   logic [1:0] mac_if_o, speed_o, gig_cap_o, mdi_mode_o, k;
   logic [2:0] rx_delay_o, tx_delay_o;
   int failures = 0;
   int checks_done = 0;
   // RMII straps paired with a 10/100 advert, except the case
   logic [RSC_NSTRAP-1:0] cfgs [8] = '{15'h04D5, 15'h0906, 15'h0EEB, 15'h001E, 15'h0072,
      15'h0042, 15'h307C, 15'h5000};
   logic [31:0] wv [5] = '{32'h3, 32'h5, 32'h1, 32'h7, 32'h6};
   logic [1:0] wk [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0};

   always #5 clk_i = ~clk_i;

   rsc_strap_board board (.clk_i, .active_low_reset_pin_n_i, .pull_i(pull), .strap_o(strap_i));
   rsc_loader dut (.clk_i, .rst_i, .active_low_reset_pin_n_i, .strap_i, .strap_oe_o, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .aux_clock_output_o, .managed_o, .phy_addr_o, .mac_if_o, .autoneg_o, .full_duplex_o,
      .speed_o, .gig_cap_o, .mdi_mode_o, .downshift_o, .low_power_o, .forced_1000_o,
      .master_o, .rx_delay_o, .tx_delay_o, .loaded_o);

   // ****************************************
   // Tasks
   // ****************************************
   task stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         failures++;
         stop_test;
      end
   endtask

   task load(input logic [RSC_NSTRAP-1:0] s);
      int n;
      @(posedge clk_i);
      pull <= s;
      active_low_reset_pin_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      // Ignored while held: the clock register must come back from the straps
      wb(1'b1, RSC_ADDR_CLK, 32'h7);
      active_low_reset_pin_n_i <= 1'b1;
      n = 0;
      while (loaded_o !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (loaded_o !== 1'b1) begin
         failures++;
         stop_test;
      end
      repeat (2) @(posedge clk_i);
   endtask

   // Toggle count over 40 cycles: 0 stopped, 1 slow, 2 fast
   task measure(output logic [1:0] cat);
      logic p;
      int c;
      c = 0;
      @(posedge clk_i);
      p = aux_clock_output_o;
      repeat (40) begin
         @(posedge clk_i);
         if (aux_clock_output_o !== p) c++;
         p = aux_clock_output_o;
      end
      cat = (c == 0) ? 2'h0 : (c < 30) ? 2'h1 : 2'h2;
   endtask

   task check_cfg(input logic [RSC_NSTRAP-1:0] s);
      logic um;
      logic [1:0] cd;
      logic [1:0] mx;
      um = s[RSC_S_MODE];
      cd = {s[4], s[5]};
      mx = s[7] ? RSC_MAC_GMII : RSC_MAC_RGMII;
      if (um && s[RSC_S_E]) mx = RSC_MAC_RMII;
      chk(strap_oe_o, 32'h0);
      chk(managed_o, !um);
      chk(phy_addr_o, um ? {3'h0, s[RSC_S_AD1], s[RSC_S_AD0]} : s[6:2]);
      chk(mac_if_o, mx);
      chk(forced_1000_o, s[12]);
      if (s[12]) begin
         chk(master_o, s[13]);
         chk(mdi_mode_o, s[14] ? RSC_MDIX_FORCE : RSC_MDI_FORCE);
         chk(speed_o, RSC_SPD_1000);
      end
      if (um) begin
         chk({rx_delay_o, tx_delay_o}, {2{s[2], s[3], 1'b0}});
         chk({downshift_o, low_power_o}, 2'h3);
         if (!s[12]) begin
            chk(autoneg_o, !cd[1]);
            if (cd[1]) begin
               chk({full_duplex_o, speed_o}, {1'b0, cd[0] ? RSC_SPD_10 : RSC_SPD_100});
            end else begin
               chk(gig_cap_o, cd[0] ? RSC_CAP_NONE : RSC_CAP_ALL);
            end
         end
      end
      wb(1'b0, RSC_ADDR_STRAP, 32'h0);
      chk(rdat, s);
      wb(1'b0, RSC_ADDR_CLK, 32'h0);
      chk(rdat[2:0], {s[RSC_S_F1], s[RSC_S_F0], s[RSC_S_AUXCLK]});
      measure(k);
      chk(k, s[0] ? ((s[11] ^ s[10]) ? 2'h2 : 2'h1) : 2'h0);
      if (!s[0]) chk(aux_clock_output_o, 32'h0);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (cfgs[i]) begin
         load(cfgs[i]);
         check_cfg(cfgs[i]);
         // Shared pins now carry traffic; settings must not follow them
         repeat (30) @(posedge clk_i);
         check_cfg(cfgs[i]);
      end
      foreach (wv[i]) begin
         wb(1'b1, RSC_ADDR_CLK, wv[i]);
         wb(1'b0, RSC_ADDR_CLK, 32'h0);
         chk(rdat[2:0], wv[i][2:0]);
         measure(k);
         chk(k, wk[i]);
      end
      // Software rewrites the derived settings; forced-gigabit bit stays as strapped
      wb(1'b1, RSC_ADDR_CFG, 32'h1485);
      wb(1'b0, RSC_ADDR_CFG, 32'h0);
      chk(rdat, 32'h3485);
      chk({autoneg_o, full_duplex_o, speed_o}, {1'b1, 1'b0, RSC_SPD_100});
      chk({mac_if_o, master_o, downshift_o}, {RSC_MAC_RMII, 2'h3});
      wb(1'b1, RSC_ADDR_DELAY, 32'h35);
      wb(1'b0, RSC_ADDR_DELAY, 32'h0);
      chk(rdat, 32'h35);
      chk({rx_delay_o, tx_delay_o}, {3'h3, 3'h5});
      wb(1'b1, RSC_ADDR_STRAP, 32'h0);
      wb(1'b0, RSC_ADDR_STRAP, 32'h0);
      chk(rdat, 32'h5000);
      wb(1'b0, RSC_ADDR_ID, 32'h0);
      chk(rdat, RSC_ID_VALUE);
      wb(1'b0, 8'h40, 32'h0);
      chk(rdat, 32'h0);
      stop_test;
   end
endmodule
